/* sim/edr_ecc_dual_port_ram_chk.sv */
// Checker: port-level properties of the protected dual-port RAM
`timescale 1ns/1ps

module edr_ecc_dual_port_ram_chk
   import edr_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus handshake
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Memory ports
   input wire edr_pkg::edr_wr_t wr_port,
   input wire logic [7:0] check_bits_out,
   input wire edr_pkg::edr_rd_t rd_port,
   input wire edr_pkg::edr_res_t rd_result
);
   wire logic sef = rd_result.single_error_flag;
   wire logic def = rd_result.double_error_flag;
   wire logic rs = rd_port.read_strobe;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // --------
   // Properties
   // --------
   a_flags_exclusive: assert property (!(sef && def))
      else $error("both error flags high");
   a_result_holds: assert property (!rs && !$past(rs) |=> $stable(rd_result))
      else $error("read result moved without a read");
   a_check_follows: assert property ($past(hresetn) && $stable(wr_port.write_data_in)
      |=> $stable(check_bits_out))
      else $error("check bits moved with steady data");
   a_single_cause: assert property ($rose(sef) |-> $past(rs) || $past(rs, 2))
      else $error("single flag rose without a read");
   a_double_cause: assert property ($rose(def) |-> $past(rs) || $past(rs, 2))
      else $error("double flag rose without a read");
   a_reset_clear: assert property (disable iff (1'h0)
      !hresetn |-> rd_result == '0 && check_bits_out == 8'h00)
      else $error("outputs not cleared in reset");
   a_bus_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
      else $error("wait state not one cycle");
   a_bus_okay: assert property (!hresp)
      else $error("response not okay");

   c_single: cover property (sef);
   c_double: cover property (def);
   c_same_loc: cover property (rs && wr_port.write_strobe
      && wr_port.write_location == rd_port.read_location);
endmodule

bind edr_ecc_dual_port_ram edr_ecc_dual_port_ram_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .wr_port(wr_port), .check_bits_out(check_bits_out), .rd_port(rd_port),
   .rd_result(rd_result));

/* sim/edr_ecc_dual_port_ram_tb.sv */
// Testbench: modes, error injection and bus access for the protected RAM
`timescale 1ns/1ps

module edr_ecc_dual_port_ram_tb;
   import edr_pkg::*;

   logic hclk = 1'h0;
   logic hresetn = 1'h1;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   edr_wr_t wr_port;
   edr_rd_t rd_port;
   logic [7:0] check_bits_out;
   edr_res_t rd_result;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rv;
   logic [63:0] d = 64'h0123_4567_89AB_CDEF;
   logic [63:0] v;
   logic [63:0] fd [4] = '{64'h0, 64'h1, 64'h3, 64'h0};
   logic [7:0] fc [4] = '{8'h01, 8'h00, 8'h00, 8'h80};

   edr_ecc_dual_port_ram DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .wr_port(wr_port),
      .check_bits_out(check_bits_out), .rd_port(rd_port), .rd_result(rd_result));
   edr_fabric fab (.hclk(hclk), .wr_port(wr_port), .rd_port(rd_port));

   always #10 hclk = ~hclk;

   // Hang guard, well above the fewer than two hundred cycles the run needs
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end

   // --------
   // Helpers
   // --------
   // Own encoder: check bit i at position 2^i, bit 7 even overall parity
   function automatic logic [7:0] enc(input logic [63:0] x);
      logic [6:0] s;
      int k;
      s = 7'h00;
      k = 0;
      for (int p = 3; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (x[k]) s = s ^ 7'(p);
            k++;
         end
      end
      return {^{x, s}, s};
   endfunction

   task automatic cmp(input logic [73:0] got, input logic [73:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'h1);
      r = hrdata;
   endtask

   task automatic reg_chk(input logic [31:0] a, input logic [31:0] e);
      ahb(1'h0, a, 32'h0000_0000, rv);
      cmp(rv, e);
   endtask

   task automatic set_mode(input logic [31:0] m);
      ahb(1'h1, 32'h0000_0000, m, rv);
   endtask

   // With the pipeline on, the result must not move at the first edge
   task automatic rd_chk(input logic [8:0] a, input logic p, input logic [73:0] e);
      logic [73:0] o;
      o = rd_result;
      fab.read_word(a);
      #1;
      if (p) begin
         cmp(rd_result, o);
         @(posedge hclk);
         #1;
      end
      cmp(rd_result, e);
   endtask

   task automatic conclude();
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // --------
   // Sequence
   // --------
   initial begin
      // Falling edge at time zero clears the flops before the first sample
      hresetn <= 1'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      reg_chk(OFS_CTRL, 32'h0000_0000);
      reg_chk(OFS_STATUS, 32'h0000_0000);
      reg_chk(32'h0000_0040, 32'h0000_0000);
      // Off mode: raw word and raw check bits, no flags
      fab.write_word(1'h1, 9'h000, d, 8'h5A);
      rd_chk(9'h000, 1'h0, {d, 8'h5A, 2'h0});
      set_mode(32'h0000_0003);
      for (int i = 0; i < 2; i++) begin
         v = d ^ {55'h0, 9'(i * 511)};
         fab.write_word(1'h1, 9'(i * 511), v, ~enc(v));
         #1;
         cmp(check_bits_out, enc(v));
         rd_chk(9'(i * 511), 1'h0, {v, enc(v), 2'h0});
      end
      fab.write_word(1'h0, 9'h000, ~d, 8'h00);
      rd_chk(9'h000, 1'h0, {d, enc(d), 2'h0});
      set_mode(32'h0000_0001);
      v = ~d;
      fab.write_word(1'h1, 9'h1FF, v, 8'h00);
      rd_chk(9'h1FF, 1'h0, {v, enc(v), 2'h0});
      set_mode(32'h0000_0002);
      for (int i = 0; i < 4; i++) begin
         fab.write_word(1'h1, 9'h0A5, d ^ fd[i], enc(d) ^ fc[i]);
         v = (i == 2) ? d ^ fd[i] : d;
         rd_chk(9'h0A5, 1'h0, {v, enc(d), i != 2, i == 2});
         rd_chk(9'h0A5, 1'h0, {v, enc(d), i != 2, i == 2});
      end
      reg_chk(OFS_STATUS, 32'h0000_0021);
      reg_chk(OFS_SBE_CNT, 32'h0000_0006);
      reg_chk(OFS_DBE_CNT, 32'h0000_0002);
      ahb(1'h1, OFS_SBE_CNT, 32'h0000_0000, rv);
      reg_chk(OFS_SBE_CNT, 32'h0000_0000);
      reg_chk(OFS_DBE_CNT, 32'h0000_0002);
      set_mode(32'h0000_0007);
      v = ~d;
      fab.write_word(1'h1, 9'h003, v, 8'h00);
      rd_chk(9'h003, 1'h1, {v, enc(v), 2'h0});
      set_mode(32'h0000_0008);
      reg_chk(OFS_STATUS, 32'h0000_0030);
      fab.write_word(1'h1, 9'h004, d, 8'h00);
      rd_chk(9'h004, 1'h0, {d, enc(d), 2'h0});
      // Same location written and read at one edge: old word comes out
      set_mode(32'h0000_0003);
      fork
         fab.write_word(1'h1, 9'h003, d, 8'h00);
         fab.read_word(9'h003);
      join
      #1;
      cmp(rd_result, {v, enc(v), 2'h0});
      rd_chk(9'h003, 1'h0, {d, enc(d), 2'h0});
      // Reset in mid-run must drop the mode and clear the read result
      @(posedge hclk);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      #1;
      cmp(rd_result, 74'h0);
      reg_chk(OFS_CTRL, 32'h0000_0000);
      reg_chk(OFS_SBE_CNT, 32'h0000_0000);
      conclude();
   end
endmodule

/* sim/edr_fabric.sv */
// Fabric model driving the write and read ports of the protected RAM
`timescale 1ns/1ps

module edr_fabric
   import edr_pkg::*;
(
   // Clock
   input wire logic hclk,
   // Ports toward the memory
   output edr_pkg::edr_wr_t wr_port,
   output edr_pkg::edr_rd_t rd_port
);
   // --------
   // Port drivers
   // --------
   // Set/reset pin absent, so it stays low by construction
   initial begin
      wr_port = '0;
      rd_port = '0;
   end

   // Strobe high writes one word, low leaves memory alone
   task automatic write_word(input logic en, input logic [8:0] a, input logic [63:0] d,
                             input logic [7:0] c);
      @(posedge hclk);
      wr_port <= '{en, a, d, c};
      @(posedge hclk);
      // Released lines show the inverse, never a stale copy
      wr_port <= '{1'h0, ~a, ~d, ~c};
   endtask

   // One read per call; same-address timing left to the caller
   task automatic read_word(input logic [8:0] a);
      @(posedge hclk);
      rd_port <= '{1'h1, a};
      @(posedge hclk);
      rd_port <= '{1'h0, ~a};
   endtask
endmodule

/* verilog/edr_ecc_dual_port_ram.sv */
// ECC-protected 512 x 64 simple dual-port RAM with AHB-Lite configuration
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps

module edr_ecc_dual_port_ram (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Write port
   input wire edr_pkg::edr_wr_t wr_port,
   output logic [7:0] check_bits_out,
   // Read port
   input wire edr_pkg::edr_rd_t rd_port,
   output edr_pkg::edr_res_t rd_result
);
   import edr_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // No reset on the array: contents are undefined until written
   logic [WORD_W-1:0] mem [DEPTH];

   logic [CTRL_W-1:0] ctrl_reg;
   logic [CTRL_W-1:0] ctrl_next;
   logic [7:0] check_bits_reg;
   edr_res_t stage_reg;
   logic stage_vld_reg;
   edr_res_t out_reg;
   edr_res_t out_next;
   logic [CNT_W-1:0] sbe_cnt_reg;
   logic [CNT_W-1:0] sbe_cnt_next;
   logic [CNT_W-1:0] dbe_cnt_reg;
   logic [CNT_W-1:0] dbe_cnt_next;
   logic dp_act_reg;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic hresp_reg;

   // ---------------------------------------------------------------
   // Mode selection
   // ---------------------------------------------------------------
   // Lock bit models the FIFO flavour, which only runs standard mode
   wire enc_on = ctrl_reg[CTRL_ENC_BIT] | ctrl_reg[CTRL_LOCK_BIT];
   wire dec_on = ctrl_reg[CTRL_DEC_BIT] | ctrl_reg[CTRL_LOCK_BIT];
   wire pipe_on = ctrl_reg[CTRL_PIPE_BIT];
   edr_mode_t mode;
   assign mode = edr_mode_t'({dec_on, enc_on});

   // ---------------------------------------------------------------
   // Write side
   // ---------------------------------------------------------------
   wire [7:0] enc_chk = edr_encode(wr_port.write_data_in);
   // Standard mode drops the external check bits; decode-only uses them
   wire [7:0] store_chk = enc_on ? enc_chk : wr_port.check_bits_in;
   wire wr_go = wr_port.write_strobe;

   // Dedicated write port with a 9-bit location
   always_ff @(posedge hclk) begin
      if (wr_go) begin
         mem[wr_port.write_location] <= {wr_port.write_data_in, store_chk};
      end
   end

   // Encoder result follows every edge, whether or not a write occurs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         check_bits_reg <= 8'h00;
      end else begin
         check_bits_reg <= enc_chk;
      end
   end

   // ---------------------------------------------------------------
   // Read side
   // ---------------------------------------------------------------
   // Array read sees the old word on a same-address write: read-first only
   wire [WORD_W-1:0] raw_word = mem[rd_port.read_location];
   edr_res_t dec_res;
   edr_res_t raw_res;
   edr_res_t rd_now;
   assign dec_res = edr_decode(raw_word[WORD_W-1:CW], raw_word[CW-1:0]);
   assign raw_res = '{raw_word[WORD_W-1:CW], raw_word[CW-1:0], 1'b0, 1'b0};
   // Corrected word leaves only through the output, never written back
   assign rd_now = dec_on ? dec_res : raw_res;
   wire rd_go = rd_port.read_strobe;

   // Output loads straight from the array, or one cycle later via stage
   assign out_next = pipe_on ? (stage_vld_reg ? stage_reg : out_reg)
                             : (rd_go ? rd_now : out_reg);
   wire out_load = pipe_on ? stage_vld_reg : rd_go;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage_reg <= '0;
         stage_vld_reg <= 1'b0;
      end else begin
         stage_reg <= rd_go ? rd_now : stage_reg;
         stage_vld_reg <= rd_go;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   // ---------------------------------------------------------------
   // Error counters
   // ---------------------------------------------------------------
   wire sbe_evt = out_load & out_next.single_error_flag;
   wire dbe_evt = out_load & out_next.double_error_flag;

   // ---------------------------------------------------------------
   // AHB-Lite slave: one wait state per transfer
   // ---------------------------------------------------------------
   // The wait state lets a write land before any following read samples
   wire addr_ok = hsel & hready & htrans[1];
   wire sel_ctrl = dp_addr_reg == OFS_CTRL;
   wire sel_status = dp_addr_reg == OFS_STATUS;
   wire sel_sbe = dp_addr_reg == OFS_SBE_CNT;
   wire sel_dbe = dp_addr_reg == OFS_DBE_CNT;
   wire bus_wr = dp_act_reg & dp_write_reg;
   wire bus_rd = dp_act_reg & ~dp_write_reg;
   wire clr_sbe = bus_wr & sel_sbe;
   wire clr_dbe = bus_wr & sel_dbe;

   assign ctrl_next = (bus_wr & sel_ctrl) ? hwdata[CTRL_W-1:0] : ctrl_reg;

   // Event in the clearing cycle is kept: count restarts at one
   assign sbe_cnt_next = clr_sbe ? CNT_W'(sbe_evt)
                       : (sbe_cnt_reg == CNT_MAX) ? sbe_cnt_reg
                       : sbe_cnt_reg + CNT_W'(sbe_evt);
   assign dbe_cnt_next = clr_dbe ? CNT_W'(dbe_evt)
                       : (dbe_cnt_reg == CNT_MAX) ? dbe_cnt_reg
                       : dbe_cnt_reg + CNT_W'(dbe_evt);

   wire [31:0] status_val = {26'h000_0000, mode, 2'b00,
                             out_reg.double_error_flag, out_reg.single_error_flag};
   wire [31:0] rd_val = sel_ctrl ? {28'h000_0000, ctrl_reg}
                      : sel_status ? status_val
                      : sel_sbe ? {16'h0000, sbe_cnt_reg}
                      : sel_dbe ? {16'h0000, dbe_cnt_reg}
                      : DATA_ZERO;
   assign hrdata_next = bus_rd ? rd_val : hrdata_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_act_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
      end else begin
         dp_act_reg <= addr_ok;
         dp_write_reg <= addr_ok ? hwrite : dp_write_reg;
         dp_addr_reg <= addr_ok ? haddr[7:0] : dp_addr_reg;
         hreadyout_reg <= ~addr_ok;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         sbe_cnt_reg <= '0;
         dbe_cnt_reg <= '0;
         hrdata_reg <= DATA_ZERO;
         hresp_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         sbe_cnt_reg <= sbe_cnt_next;
         dbe_cnt_reg <= dbe_cnt_next;
         hrdata_reg <= hrdata_next;
         hresp_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;
   assign hresp = hresp_reg;
   assign check_bits_out = check_bits_reg;
   assign rd_result = out_reg;

endmodule

/* verilog/edr_pkg.sv */
// Package: sizes, register map, carriers and Hamming helpers for the ECC dual-port RAM
package edr_pkg;

   // ---------------------------------------------------------------
   // Memory geometry
   // ---------------------------------------------------------------
   localparam int DEPTH = 512;
   localparam int AW = 9;
   localparam int DW = 64;
   localparam int CW = 8;
   localparam int WORD_W = 72;
   localparam int CODE_TOP = 71;

   // ---------------------------------------------------------------
   // Register map (byte offsets, low address byte decoded)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SBE_CNT = 8'h08;
   localparam logic [7:0] OFS_DBE_CNT = 8'h0C;
   localparam int CTRL_W = 4;
   localparam int CTRL_ENC_BIT = 0;
   localparam int CTRL_DEC_BIT = 1;
   localparam int CTRL_PIPE_BIT = 2;
   localparam int CTRL_LOCK_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ENC = 2'b01,
      MODE_DEC = 2'b10,
      MODE_STD = 2'b11
   } edr_mode_t;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic write_strobe;
      logic [8:0] write_location;
      logic [63:0] write_data_in;
      logic [7:0] check_bits_in;
   } edr_wr_t;

   typedef struct packed {
      logic read_strobe;
      logic [8:0] read_location;
   } edr_rd_t;

   typedef struct packed {
      logic [63:0] read_data_out;
      logic [7:0] stored_check_bits_out;
      logic single_error_flag;
      logic double_error_flag;
   } edr_res_t;

   // ---------------------------------------------------------------
   // Hamming helpers: code bit 0 is overall parity, powers of two
   // hold check bits 0..6, all other positions hold data
   // ---------------------------------------------------------------
   function automatic logic [71:0] edr_spread(input logic [63:0] d, input logic [7:0] c);
      logic [71:0] w;
      int k;
      int i;
      w = '0;
      k = 0;
      i = 0;
      w[0] = c[7];
      for (int p = 1; p <= CODE_TOP; p++) begin
         if ((p & (p - 1)) == 0) begin
            w[p] = c[i];
            i++;
         end else begin
            w[p] = d[k];
            k++;
         end
      end
      return w;
   endfunction

   function automatic logic [71:0] edr_gather(input logic [71:0] w);
      logic [63:0] d;
      logic [7:0] c;
      int k;
      int i;
      d = '0;
      c = '0;
      k = 0;
      i = 0;
      c[7] = w[0];
      for (int p = 1; p <= CODE_TOP; p++) begin
         if ((p & (p - 1)) == 0) begin
            c[i] = w[p];
            i++;
         end else begin
            d[k] = w[p];
            k++;
         end
      end
      return {d, c};
   endfunction

   function automatic logic [6:0] edr_syndrome(input logic [71:0] w);
      logic [6:0] s;
      s = '0;
      for (int p = 1; p <= CODE_TOP; p++) begin
         if (w[p]) begin
            s = s ^ 7'(p);
         end
      end
      return s;
   endfunction

   function automatic logic [7:0] edr_encode(input logic [63:0] d);
      logic [6:0] s;
      s = edr_syndrome(edr_spread(d, 8'h00));
      return {^{d, s}, s};
   endfunction

   function automatic edr_res_t edr_decode(input logic [63:0] d, input logic [7:0] c);
      edr_res_t r;
      logic [71:0] w;
      logic [71:0] g;
      logic [6:0] s;
      logic ov;
      w = edr_spread(d, c);
      s = edr_syndrome(w);
      ov = ^w;
      r.single_error_flag = 1'b0;
      r.double_error_flag = 1'b0;
      if (ov && s == 7'd0) begin
         w[0] = ~w[0];
         r.single_error_flag = 1'b1;
      end else if (ov && int'(s) <= CODE_TOP) begin
         w[s] = ~w[s];
         r.single_error_flag = 1'b1;
      end else if (s != 7'd0) begin
         // Even flip count or syndrome off the word: not correctable
         r.double_error_flag = 1'b1;
      end
      g = edr_gather(w);
      r.read_data_out = g[71:8];
      r.stored_check_bits_out = g[7:0];
      return r;
   endfunction

endpackage
